// ==== setws_pkg.sv ====
package setws_pkg;
   localparam int MEM_BYTES = 8192;
   localparam int ADDR_W = 13;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;
   localparam int BASE_W = ADDR_W - PAGE_W;
   localparam logic [3:0] TYPE_MAIN = 4'ha;
   localparam logic [3:0] TYPE_ID = 4'hb;
   // select byte layout: type code, straps, direction
   localparam int SEL_TYPE_HI = 7;
   localparam int SEL_TYPE_LO = 4;
   localparam int SEL_STRAP_HI = 3;
   localparam int SEL_STRAP_LO = 1;
   localparam int SEL_RW = 0;
   // lock instruction: address bit 10 in the high byte, data bit 1
   localparam int LOCK_ABIT = 2;
   localparam int LOCK_DBIT = 1;
   localparam int BITS_PER_BYTE = 8;
   localparam int LAST_TX_BIT = 7;
   localparam int WRITE_TIME_US = 5;
   localparam int WRITE_TIME_NS = WRITE_TIME_US * 1000;
   localparam int CLK_PERIOD_NS = 40;
   // longest time, so round down
   localparam int WRITE_CYCLES = WRITE_TIME_NS * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_ACK,
      ST_SEND,
      ST_MACK
   } setws_state_e;

   typedef enum logic [1:0] {
      RL_SEL,
      RL_AHI,
      RL_ALO,
      RL_DATA
   } setws_role_e;

   typedef struct packed {
      logic bit2;
      logic bit1;
      logic bit0;
   } setws_strap_s;

   typedef struct packed {
      logic active;
      logic id_sel;
      logic lock;
      logic [BASE_W-1:0] base;
   } setws_prog_s;
endpackage

// ==== setws_eeprom.sv ====
// Behaviour
// - 8192 bytes in 32-byte write pages
// - self-timed program cycle within five milliseconds
// - partial pages program only received bytes
// - extra id page, writable until locked
// - bus ignored while supply below threshold
// - supply good resets control, enters standby
// - supply loss drops to standby, abandons bus
// - standby after stop unless write running
// - write-protect high blocks main array writes
// - open strap inputs read as zero
// - straps compared with received bus address
// - data line only pulled low or released
// - select byte, address bytes, then data
// - type 1010 or 1011, straps, then read/write bit
// - page write wraps low five address bits
// - stop starts programming, bus ignored meanwhile
// - write select unacknowledged while programming
`timescale 1ns/10ps
`default_nettype none
module setws_eeprom #(
   parameter int WRITE_CYCLES = setws_pkg::WRITE_CYCLES
) (
   input wire logic clk_sys, // system clock, 25 MHz
   input wire logic sys_rst, // asynchronous reset, active high
   input wire logic scl_link, // bus serial clock from the master
   input wire logic sda_in, // data line level
   output logic sda_out, // data line drive value, always low
   output logic sda_oe, // high while pulling the data line low
   input wire setws_pkg::setws_strap_s strap_in, // address straps
   input wire logic wp_in, // write protect, high blocks array writes
   input wire logic por_ok, // supply above power-on threshold
   output logic busy, // internal programming in progress
   output logic standby // idle and not programming
);
   localparam int CW = $clog2(WRITE_CYCLES + 1);

   // link domain: capture the data bit on each serial clock rise
   logic bit_reg, bit_next, tgl_reg, tgl_next;
   always_comb begin
      bit_next = sda_in;
      tgl_next = ~tgl_reg;
   end
   always_ff @(posedge scl_link or posedge sys_rst) begin
      if (sys_rst) begin
         bit_reg <= 1'b0;
         tgl_reg <= 1'b0;
      end else begin
         bit_reg <= bit_next;
         tgl_reg <= tgl_next;
      end
   end

   // pins and link events into the system domain
   // toggle gets two extra stages so the captured bit is settled first
   logic [1:0] scl_sy, sda_sy, wp_sy, por_sy, bit_sy;
   logic [3:0] tgl_sy;
   setws_pkg::setws_strap_s strap_s1, strap_s2;
   logic scl_q, sda_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         wp_sy <= 2'h0;
         por_sy <= 2'h0;
         bit_sy <= 2'h0;
         tgl_sy <= 4'h0;
         strap_s1 <= '0;
         strap_s2 <= '0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], scl_link};
         sda_sy <= {sda_sy[0], sda_in};
         wp_sy <= {wp_sy[0], wp_in};
         por_sy <= {por_sy[0], por_ok};
         bit_sy <= {bit_sy[0], bit_reg};
         tgl_sy <= {tgl_sy[2:0], tgl_reg};
         strap_s1 <= strap_in;
         strap_s2 <= strap_s1;
         scl_q <= scl_sy[1];
         sda_q <= sda_sy[1];
      end
   end

   logic start_evt, stop_evt, rise_evt, fall_evt, wp_s, por_s, bit_s;
   assign wp_s = wp_sy[1];
   assign por_s = por_sy[1];
   assign bit_s = bit_sy[1];
   assign start_evt = scl_sy[1] & scl_q & sda_q & ~sda_sy[1];
   assign stop_evt = scl_sy[1] & scl_q & ~sda_q & sda_sy[1];
   assign rise_evt = tgl_sy[3] ^ tgl_sy[2];
   assign fall_evt = scl_q & ~scl_sy[1];

   logic [7:0] mem [setws_pkg::MEM_BYTES];
   logic [7:0] idm [setws_pkg::PAGE_BYTES];
   logic [7:0] pbuf [setws_pkg::PAGE_BYTES];

   function automatic logic [7:0] rd_byte(input logic id,
         input logic [setws_pkg::ADDR_W-1:0] a);
      rd_byte = id ? idm[a[setws_pkg::PAGE_W-1:0]] : mem[a];
   endfunction

   setws_pkg::setws_state_e st_reg, st_next;
   setws_pkg::setws_role_e role_reg, role_next;
   setws_pkg::setws_prog_s prog_reg, prog_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next, tx_reg, tx_next, ahi_reg, ahi_next;
   logic [setws_pkg::ADDR_W-1:0] ptr_reg, ptr_next;
   logic [setws_pkg::PAGE_BYTES-1:0] mask_reg, mask_next;
   logic [CW-1:0] pc_reg, pc_next;
   logic oe_reg, oe_next, id_reg, id_next, lk_reg, lk_next;
   logic pend_reg, pend_next, lock_reg, lock_next, mack_reg, mack_next;
   logic locked_reg, locked_next;
   logic pb_we, sel_ok, prog_go;
   logic [setws_pkg::PAGE_W-1:0] pb_idx;

   always_comb begin
      st_next = st_reg;
      role_next = role_reg;
      prog_next = prog_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      tx_next = tx_reg;
      ahi_next = ahi_reg;
      ptr_next = ptr_reg;
      mask_next = mask_reg;
      pc_next = pc_reg;
      oe_next = oe_reg;
      id_next = id_reg;
      lk_next = lk_reg;
      pend_next = pend_reg;
      lock_next = lock_reg;
      mack_next = mack_reg;
      locked_next = locked_reg;
      pb_we = 1'b0;
      pb_idx = ptr_reg[setws_pkg::PAGE_W-1:0];
      sel_ok = ((sh_reg[setws_pkg::SEL_TYPE_HI:setws_pkg::SEL_TYPE_LO]
            == setws_pkg::TYPE_MAIN)
         || (sh_reg[setws_pkg::SEL_TYPE_HI:setws_pkg::SEL_TYPE_LO]
            == setws_pkg::TYPE_ID))
         && sh_reg[setws_pkg::SEL_STRAP_HI:setws_pkg::SEL_STRAP_LO]
            == strap_s2
         && !prog_reg.active;
      prog_go = pend_reg && (id_reg ? !locked_reg : !wp_s);
      // self-timed cycle runs from the system clock alone
      if (prog_reg.active) begin
         pc_next = pc_reg + CW'(1);
         if (pc_reg == CW'(WRITE_CYCLES - 1)) begin
            prog_next.active = 1'b0;
            if (prog_reg.lock)
               locked_next = 1'b1;
         end
      end
      case (st_reg)
         setws_pkg::ST_IDLE: ;
         setws_pkg::ST_RECV: begin
            if (rise_evt && cnt_reg != 4'(setws_pkg::BITS_PER_BYTE)) begin
               sh_next = {sh_reg[6:0], bit_s};
               cnt_next = cnt_reg + 4'h1;
            end else if (fall_evt
                  && cnt_reg == 4'(setws_pkg::BITS_PER_BYTE)) begin
               st_next = setws_pkg::ST_ACK;
               oe_next = 1'b1;
               case (role_reg)
                  setws_pkg::RL_SEL: begin
                     oe_next = sel_ok;
                     if (!sel_ok)
                        st_next = setws_pkg::ST_IDLE;
                     id_next = sh_reg[setws_pkg::SEL_TYPE_LO];
                     lk_next = sh_reg[setws_pkg::SEL_RW];
                     // a refused poll must not clear a page still committing
                     if (sel_ok && !sh_reg[setws_pkg::SEL_RW]) begin
                        mask_next = '0;
                        pend_next = 1'b0;
                        lock_next = 1'b0;
                     end
                  end
                  setws_pkg::RL_AHI: ahi_next = sh_reg;
                  setws_pkg::RL_ALO:
                     ptr_next = setws_pkg::ADDR_W'({ahi_reg, sh_reg});
                  default: begin
                     if (id_reg && locked_reg) begin
                        oe_next = 1'b0; // locked id page refuses data
                        st_next = setws_pkg::ST_IDLE;
                     end else if (id_reg && ahi_reg[setws_pkg::LOCK_ABIT])
                     begin
                        lock_next = sh_reg[setws_pkg::LOCK_DBIT];
                        pend_next = sh_reg[setws_pkg::LOCK_DBIT];
                     end else begin
                        pb_we = 1'b1;
                        mask_next[pb_idx] = 1'b1;
                        pend_next = 1'b1;
                        ptr_next[setws_pkg::PAGE_W-1:0] =
                           pb_idx + setws_pkg::PAGE_W'(1);
                     end
                  end
               endcase
            end
         end
         setws_pkg::ST_ACK: begin
            if (fall_evt) begin
               cnt_next = 4'h0;
               if (role_reg == setws_pkg::RL_SEL && lk_reg) begin
                  st_next = setws_pkg::ST_SEND;
                  tx_next = rd_byte(id_reg, ptr_reg);
                  oe_next = ~tx_next[setws_pkg::LAST_TX_BIT];
                  ptr_next = ptr_reg + setws_pkg::ADDR_W'(1);
               end else begin
                  st_next = setws_pkg::ST_RECV;
                  oe_next = 1'b0;
                  if (role_reg != setws_pkg::RL_DATA)
                     role_next = setws_pkg::setws_role_e'(role_reg + 2'h1);
               end
            end
         end
         setws_pkg::ST_SEND: begin
            if (fall_evt) begin
               cnt_next = cnt_reg + 4'h1;
               // fall after bit 0 hands the line to the master's ack
               if (cnt_reg == 4'(setws_pkg::LAST_TX_BIT)) begin
                  st_next = setws_pkg::ST_MACK;
                  oe_next = 1'b0;
               end else begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  oe_next = ~tx_reg[setws_pkg::LAST_TX_BIT - 1];
               end
            end
         end
         setws_pkg::ST_MACK: begin
            if (rise_evt)
               mack_next = bit_s;
            if (fall_evt) begin
               cnt_next = 4'h0;
               if (!mack_reg) begin
                  st_next = setws_pkg::ST_SEND;
                  tx_next = rd_byte(id_reg, ptr_reg);
                  oe_next = ~tx_next[setws_pkg::LAST_TX_BIT];
                  ptr_next = ptr_reg + setws_pkg::ADDR_W'(1);
               end else
                  st_next = setws_pkg::ST_IDLE;
            end
         end
         default: st_next = setws_pkg::ST_IDLE;
      endcase
      if (start_evt) begin // master owns start and stop
         st_next = setws_pkg::ST_RECV;
         role_next = setws_pkg::RL_SEL;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end
      if (stop_evt) begin
         st_next = setws_pkg::ST_IDLE;
         oe_next = 1'b0;
         pend_next = 1'b0;
         if (prog_go && !prog_reg.active) begin
            prog_next.active = 1'b1;
            prog_next.id_sel = id_reg;
            prog_next.lock = lock_reg;
            prog_next.base = ptr_reg[setws_pkg::ADDR_W-1:setws_pkg::PAGE_W];
            pc_next = '0;
         end
      end
      if (!por_s) begin
         st_next = setws_pkg::ST_IDLE;
         oe_next = 1'b0;
         pend_next = 1'b0;
         prog_next.active = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= setws_pkg::ST_IDLE;
         role_reg <= setws_pkg::RL_SEL;
         prog_reg <= '0;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         tx_reg <= 8'h00;
         ahi_reg <= 8'h00;
         ptr_reg <= '0;
         mask_reg <= '0;
         pc_reg <= '0;
         oe_reg <= 1'b0;
         id_reg <= 1'b0;
         lk_reg <= 1'b0;
         pend_reg <= 1'b0;
         lock_reg <= 1'b0;
         mack_reg <= 1'b1;
         locked_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         role_reg <= role_next;
         prog_reg <= prog_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         tx_reg <= tx_next;
         ahi_reg <= ahi_next;
         ptr_reg <= ptr_next;
         mask_reg <= mask_next;
         pc_reg <= pc_next;
         oe_reg <= oe_next;
         id_reg <= id_next;
         lk_reg <= lk_next;
         pend_reg <= pend_next;
         lock_reg <= lock_next;
         mack_reg <= mack_next;
         locked_reg <= locked_next;
      end
   end

   // arrays have no reset; only buffered bytes with mask set commit
   always_ff @(posedge clk_sys) begin
      if (pb_we)
         pbuf[pb_idx] <= sh_reg;
      if (prog_reg.active && pc_reg < CW'(setws_pkg::PAGE_BYTES)
            && mask_reg[pc_reg[setws_pkg::PAGE_W-1:0]]) begin
         if (prog_reg.id_sel)
            idm[pc_reg[setws_pkg::PAGE_W-1:0]] <=
               pbuf[pc_reg[setws_pkg::PAGE_W-1:0]];
         else
            mem[{prog_reg.base, pc_reg[setws_pkg::PAGE_W-1:0]}] <=
               pbuf[pc_reg[setws_pkg::PAGE_W-1:0]];
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign busy = prog_reg.active;
   assign standby = st_reg == setws_pkg::ST_IDLE && !prog_reg.active;

   a_sda_open_drain: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sda_oe |-> !sda_out) else $error("data line driven high");
   a_busy_no_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busy && $past(busy) |-> !sda_oe) else $error("ack while busy");
   a_prog_min_time: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $rose(busy) && por_s |=> busy [*8])
      else $error("programming ended early");
   a_prog_bounded: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busy |-> pc_reg < CW'(WRITE_CYCLES)) else $error("program overrun");
   a_wp_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stop_evt && wp_s && !id_reg && !busy |=> !busy)
      else $error("protected write started");
   a_por_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !por_s |=> standby && !sda_oe) else $error("active without supply");
   a_stop_standby: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stop_evt && !busy && !prog_go |=> standby)
      else $error("no standby after stop");
   a_page_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pb_we |=> ptr_reg[setws_pkg::ADDR_W-1:setws_pkg::PAGE_W]
         == $past(ptr_reg[setws_pkg::ADDR_W-1:setws_pkg::PAGE_W])
      && ptr_reg[setws_pkg::PAGE_W-1:0]
         == $past(pb_idx) + setws_pkg::PAGE_W'(1))
      else $error("page pointer wrong");
   a_lock_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
      locked_reg |=> locked_reg) else $error("id page unlocked");
   a_sel_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
      st_reg == setws_pkg::ST_ACK && role_reg == setws_pkg::RL_SEL && oe_reg
      |-> sh_reg[setws_pkg::SEL_STRAP_HI:setws_pkg::SEL_STRAP_LO] == strap_s2)
      else $error("ack for foreign address");
endmodule
`default_nettype wire

// ==== setws_bus_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module setws_bus_master (
   input wire logic link_clk, // 12 ns timing base of the master
   input wire logic sda_line, // resolved data line
   output logic scl_link, // serial clock, stands high between frames
   output logic sda_pull // high while the master pulls data low
);
   // 300 ns quarter bit keeps the device's two-flop sync margin
   localparam int QTR = 25;
   initial begin
      scl_link = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic qtr();
      repeat (QTR) @(posedge link_clk);
   endtask
   // also serves as repeated start from a low clock
   task automatic start();
      sda_pull <= 1'b0;
      qtr();
      scl_link <= 1'b1;
      qtr();
      sda_pull <= 1'b1;
      qtr();
      scl_link <= 1'b0;
      qtr();
   endtask
   task automatic stop();
      sda_pull <= 1'b1;
      qtr();
      scl_link <= 1'b1;
      qtr();
      sda_pull <= 1'b0;
      qtr();
   endtask
   // data only changes while the clock is low
   task automatic xfer_bit(input logic b, output logic r);
      sda_pull <= ~b;
      qtr();
      scl_link <= 1'b1;
      qtr();
      r = sda_line;
      qtr();
      scl_link <= 1'b0;
      qtr();
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
      xfer_bit(last, r);
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int WCYC = 800;
   localparam logic [3:0] TM = setws_pkg::TYPE_MAIN;
   localparam logic [3:0] TI = setws_pkg::TYPE_ID;
   logic clk_sys, link_clk, sys_rst, wp_in, por_ok, ack;
   logic scl_link, sda_pull, sda_out, sda_oe, busy, standby, sda_line;
   setws_pkg::setws_strap_s strap_in;
   logic [2:0] strap;
   logic [7:0] rd;
   logic [12:0] pa;
   int num_errors = 0;
   int compares = 0;
   int busy_len = 0;
   int last_len = 0;
   int sb_bad = 0;
   byte unsigned mem [int];
   byte unsigned idp [int];
   // pull-up: the line is low whenever either party pulls it
   assign sda_line = ~(sda_oe | sda_pull);
   setws_eeprom #(.WRITE_CYCLES(WCYC)) i_setws_eeprom (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .scl_link(scl_link), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_in(strap_in),
      .wp_in(wp_in), .por_ok(por_ok), .busy(busy), .standby(standby));
   setws_bus_master i_setws_bus_master (.link_clk(link_clk),
      .sda_line(sda_line), .scl_link(scl_link), .sda_pull(sda_pull));
   initial clk_sys = 1'b0;
   always #20 clk_sys = ~clk_sys;
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   always @(posedge clk_sys) begin
      if (busy === 1'b1) begin
         busy_len <= busy_len + 1;
         if (standby !== 1'b0) sb_bad <= sb_bad + 1;
      end else if (busy_len != 0) begin
         last_len <= busy_len;
         busy_len <= 0;
      end
   end
   task automatic stop_test();
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic tx(input logic [7:0] d);
      i_setws_bus_master.send_byte(d, ack);
   endtask
   task automatic pstop();
      i_setws_bus_master.stop();
   endtask
   task automatic sel(input logic [3:0] ty, input logic rw, input logic exp);
      i_setws_bus_master.start();
      tx({ty, strap, rw});
      chk("select ack", exp, ack);
   endtask
   task automatic wr(input logic [3:0] ty, input logic [7:0] ahi,
         input logic [7:0] alo, input int n, input logic dack, input logic keep);
      logic [12:0] a;
      logic [7:0] d;
      a = {ahi[4:0], alo};
      sel(ty, 1'b0, 1'b1);
      tx(ahi);
      chk("addr ack", 1, ack);
      tx(alo);
      chk("addr ack", 1, ack);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         tx(d);
         chk("data ack", dack, ack);
         if (keep && ty == TI) idp[int'(a[4:0])] = d;
         else if (keep) mem[int'(a)] = d;
         a[4:0] = a[4:0] + 5'd1;
      end
      pstop();
   endtask
   task automatic rdq(input logic [3:0] ty, input logic [7:0] ahi,
         input logic [7:0] alo, input int n);
      logic [12:0] a;
      a = {ahi[4:0], alo};
      sel(ty, 1'b0, 1'b1);
      tx(ahi);
      tx(alo);
      sel(ty, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_setws_bus_master.recv_byte(i == n - 1, rd);
         if (ty == TI && idp.exists(int'(a[4:0])))
            chk("id byte", idp[int'(a[4:0])], rd);
         else if (ty != TI && mem.exists(int'(a)))
            chk("array byte", mem[int'(a)], rd);
         a = a + 13'd1;
      end
      pstop();
   endtask
   // mode 0: no program cycle, 1: program cycle, 2: either
   task automatic wait_done(input int mode);
      cyc(8);
      if (mode < 2) chk("busy", mode, busy);
      if (mode == 1) begin
         sel(TM, 1'b0, 1'b0);
         pstop();
      end
      for (int i = 0; i < WCYC + 100 && busy !== 1'b0; i++) cyc(1);
      cyc(4);
      chk("standby", 1, standby);
      if (mode == 1) begin
         chk("busy length", 1, last_len <= WCYC && last_len >= WCYC - 2);
         sel(TM, 1'b0, 1'b1);
         pstop();
      end
   endtask
   initial begin
      sys_rst = 1'b1;
      wp_in = 1'b0;
      por_ok = 1'b0;
      strap_in = '0;
      strap = 3'd0;
      void'($urandom(32'hded5_1403));
      cyc(16);
      sys_rst <= 1'b0;
      cyc(2);
      chk("standby", 1, standby);
      chk("busy", 0, busy);
      sel(TM, 1'b0, 1'b0);
      pstop();
      @(posedge clk_sys);
      por_ok <= 1'b1;
      cyc(6);
      // strap value zero is the unconnected case
      for (int s = 0; s < 8; s++) begin
         @(posedge clk_sys);
         strap = 3'(s);
         strap_in <= setws_pkg::setws_strap_s'(strap);
         cyc(4);
         sel(TM, 1'b0, 1'b1);
         pstop();
         strap = strap ^ 3'(1 + $urandom_range(6));
         sel(TM, 1'b0, 1'b0);
         pstop();
         strap = 3'(s);
      end
      sel(4'h5, 1'b0, 1'b0);
      pstop();
      for (int k = 0; k < 2; k++) begin
         pa = 13'($urandom);
         wr(TM, {3'($urandom), pa[12:8]}, pa[7:0], k == 0 ? 37 : 3, 1'b1,
            1'b1);
         wait_done(1);
         rdq(TM, {3'd0, pa[12:8]}, {pa[7:5], 5'd0}, 32);
      end
      @(posedge clk_sys);
      wp_in <= 1'b1;
      cyc(4);
      wr(TM, {3'd0, pa[12:8]}, pa[7:0], 4, 1'b1, 1'b0);
      wait_done(0);
      rdq(TM, {3'd0, pa[12:8]}, pa[7:0], 4);
      @(posedge clk_sys);
      wp_in <= 1'b0;
      wr(TI, 8'h00, 8'h1c, 6, 1'b1, 1'b1);
      wait_done(1);
      rdq(TI, 8'h00, 8'h1c, 6);
      sel(TI, 1'b0, 1'b1);
      tx(8'h04);
      tx(8'h00);
      tx(8'($urandom) | 8'h02);
      chk("lock ack", 1, ack);
      pstop();
      wait_done(1);
      wr(TI, 8'h00, 8'h1c, 2, 1'b0, 1'b0);
      wait_done(2);
      rdq(TI, 8'h00, 8'h1c, 6);
      pa = pa ^ 13'h1000;
      mem.delete(int'(pa));
      wr(TM, {3'd0, pa[12:8]}, pa[7:0], 1, 1'b1, 1'b0);
      cyc(6);
      chk("busy", 1, busy);
      por_ok <= 1'b0;
      cyc(6);
      chk("busy", 0, busy);
      chk("standby", 1, standby);
      por_ok <= 1'b1;
      cyc(6);
      sel(TM, 1'b0, 1'b1);
      pstop();
      chk("sda drive value", 0, sda_out);
      chk("standby while busy", 0, sb_bad);
      stop_test();
   end
   initial begin
      cyc(95000);
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
